/* File: smba_params.svh */
// Constants for the shared memory bus arbiter
`ifndef SMBA_PARAMS_SVH
`define SMBA_PARAMS_SVH
`define SMBA_NUM_PROC 4
`define SMBA_HOLDOFF_ASSERTED 1'b0
`define SMBA_HOLDOFF_RELEASED 1'b1
`define SMBA_SYNC_STAGES 2
`define SMBA_CTRL_HOLD_BIT 8
`define SMBA_CTRL_HOLDACK_BIT 9
`define SMBA_PIN_REQ_BIT 5
`endif

/* File: smba_pkg.sv */
// Types shared by both ends of the shared memory bus arbiter
package smba_pkg;
  typedef enum logic [1:0] {
    SMBA_IDLE,
    SMBA_WAIT_FREE,
    SMBA_GRANTED
  } smba_arb_state_e;
  typedef enum logic [1:0] {
    SMBA_P_IDLE,
    SMBA_P_REQ,
    SMBA_P_OWN,
    SMBA_P_DROP
  } smba_proc_state_e;
endpackage

/* File: smba_if.sv */
// Pin bundle between the arbiter and the four processors of a column
`timescale 1ns/10ps
`default_nettype none
interface smba_if #(parameter int NUM_PROC = 4) ();
  logic [NUM_PROC-1:0] bus_request_pin;
  logic [NUM_PROC-1:0] holdoff_n;
  logic [NUM_PROC-1:0] holdoff_ack_n;
  modport arbiter (input bus_request_pin, input holdoff_ack_n, output holdoff_n);
  modport procs (output bus_request_pin, output holdoff_ack_n, input holdoff_n);
endinterface
`default_nettype wire

/* File: smba_arbiter.sv */
// Arbiter end: hands the shared external memory bus to one processor at a time
// Behaviour
// - Idle: hold off every processor
// - Processor requests bus on a spare pin
// - Wait bus free, release only requester
// - Software owns bus when both flags one
// - Grant lasts unlimited transfers
// - Request drop reasserts hold-off
// - Pending requests served one at a time
// - No pre-emption or timeout; reset only
// - Held processor floats pins, acknowledges hold
// - One arbiter serves four processors
// - Request pin driven by one control bit
// - Early access just stalls the processor
`timescale 1ns/10ps
`default_nettype none
`include "smba_params.svh"
module smba_arbiter import smba_pkg::*; #(
  parameter int NUM_PROC = `SMBA_NUM_PROC
) (
  input wire logic mclk, // Board logic clock
  input wire logic rst, // Synchronous reset, active high
  smba_if.arbiter bus, // Processor pins
  output logic [NUM_PROC-1:0] grant_ff, // One-hot current owner
  output logic bus_busy_ff // Some processor owns or awaits bus
);
  ////////////////////////////////////////////////////////////////////////
  // Both pin groups come from processor pads, so neither is trusted raw
  logic [NUM_PROC-1:0] req_meta_ff;
  logic [NUM_PROC-1:0] req_sync_ff;
  logic [NUM_PROC-1:0] ack_meta_ff;
  logic [NUM_PROC-1:0] ack_sync_ff;
  logic [NUM_PROC-1:0] nxt_req_meta;
  logic [NUM_PROC-1:0] nxt_req_sync;
  logic [NUM_PROC-1:0] nxt_ack_meta;
  logic [NUM_PROC-1:0] nxt_ack_sync;

  always_comb begin
    nxt_req_meta = bus.bus_request_pin;
    nxt_req_sync = req_meta_ff;
    nxt_ack_meta = bus.holdoff_ack_n;
    nxt_ack_sync = ack_meta_ff;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      req_meta_ff <= '0;
      req_sync_ff <= '0;
      // Acks start as not holding, so nobody is granted before they settle
      ack_meta_ff <= '1;
      ack_sync_ff <= '1;
    end else begin
      req_meta_ff <= nxt_req_meta;
      req_sync_ff <= nxt_req_sync;
      ack_meta_ff <= nxt_ack_meta;
      ack_sync_ff <= nxt_ack_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Search origin: the processor just after the most recent owner
  function automatic int rr_start(input logic [NUM_PROC-1:0] last);
    int start;
    start = 0;
    for (int i = 0; i < NUM_PROC; i++) begin
      if (last[i]) begin
        start = (i + 1) % NUM_PROC;
      end
    end
    return start;
  endfunction

  // Round-robin pick starting just after the last owner
  function automatic logic [NUM_PROC-1:0] rr_pick(input logic [NUM_PROC-1:0] req,
                                                  input logic [NUM_PROC-1:0] last);
    logic [NUM_PROC-1:0] pick;
    int start;
    int idx;
    pick = '0;
    start = rr_start(last);
    for (int k = NUM_PROC - 1; k >= 0; k--) begin
      idx = (start + k) % NUM_PROC;
      if (req[idx]) begin
        pick = '0;
        pick[idx] = 1'b1;
      end
    end
    return pick;
  endfunction

  // Bus is free only when every processor acknowledges its hold-off
  function automatic logic bus_is_free(input logic [NUM_PROC-1:0] ack_n);
    logic free;
    free = 1'b1;
    for (int i = 0; i < NUM_PROC; i++) begin
      if (ack_n[i] != 1'b0) begin
        free = 1'b0;
      end
    end
    return free;
  endfunction

  // Hold-off pins from a grant vector: only granted bits are released
  function automatic logic [NUM_PROC-1:0] holdoff_for(input logic [NUM_PROC-1:0] grant);
    logic [NUM_PROC-1:0] hold_n;
    hold_n = {NUM_PROC{`SMBA_HOLDOFF_ASSERTED}};
    for (int i = 0; i < NUM_PROC; i++) begin
      if (grant[i]) begin
        hold_n[i] = `SMBA_HOLDOFF_RELEASED;
      end
    end
    return hold_n;
  endfunction

  // Guard: a corrupted pending vector must never release two processors
  function automatic logic [NUM_PROC-1:0] keep_lowest(input logic [NUM_PROC-1:0] v);
    logic [NUM_PROC-1:0] one;
    one = '0;
    for (int i = NUM_PROC - 1; i >= 0; i--) begin
      if (v[i]) begin
        one = '0;
        one[i] = 1'b1;
      end
    end
    return one;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Hand-over takes about a dozen cycles: request sync, pick, then the
  // processors' own hold-off sync and ack must come back through our sync.
  // Slow, but no pad ever feeds a decision without two flops first.
  smba_arb_state_e state_ff;
  smba_arb_state_e nxt_state;
  logic [NUM_PROC-1:0] nxt_grant;
  logic [NUM_PROC-1:0] pend_ff;
  logic [NUM_PROC-1:0] nxt_pend;
  logic [NUM_PROC-1:0] last_ff;
  logic [NUM_PROC-1:0] nxt_last;
  logic [NUM_PROC-1:0] holdoff_n_ff;
  logic [NUM_PROC-1:0] nxt_holdoff_n;
  logic nxt_busy;

  always_comb begin
    nxt_state = state_ff;
    nxt_grant = grant_ff;
    nxt_pend = pend_ff;
    nxt_last = last_ff;
    nxt_holdoff_n = {NUM_PROC{`SMBA_HOLDOFF_ASSERTED}};
    unique case (state_ff)
      SMBA_IDLE: begin
        if (|req_sync_ff) begin
          // Pick is latched so a late request cannot steal the slot
          nxt_pend = rr_pick(req_sync_ff, last_ff);
          nxt_state = SMBA_WAIT_FREE;
        end
      end
      SMBA_WAIT_FREE: begin
        // All processors must show hold-acknowledge before anyone is released
        if ((req_sync_ff & pend_ff) == '0) begin
          // Picked processor gave up before its turn: pick again from idle
          nxt_pend = '0;
          nxt_state = SMBA_IDLE;
        end else if (bus_is_free(ack_sync_ff)) begin
          nxt_grant = keep_lowest(pend_ff);
          nxt_last = keep_lowest(pend_ff);
          nxt_state = SMBA_GRANTED;
        end
      end
      SMBA_GRANTED: begin
        // No tenure counter: owner keeps bus until it drops its request.
        // Limitation: an owner that never lets go locks the column until reset.
        if ((req_sync_ff & grant_ff) == '0) begin
          nxt_grant = '0;
          nxt_pend = '0;
          nxt_state = SMBA_IDLE;
        end
      end
      default: nxt_state = SMBA_IDLE;
    endcase
    nxt_holdoff_n = holdoff_for(nxt_grant);
    nxt_busy = (nxt_state != SMBA_IDLE);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      // Reset cuts an owner off at once, even in the middle of a burst
      state_ff <= SMBA_IDLE;
      grant_ff <= '0;
      pend_ff <= '0;
      last_ff <= '0;
      holdoff_n_ff <= {NUM_PROC{`SMBA_HOLDOFF_ASSERTED}};
      bus_busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      grant_ff <= nxt_grant;
      pend_ff <= nxt_pend;
      last_ff <= nxt_last;
      holdoff_n_ff <= nxt_holdoff_n;
      bus_busy_ff <= nxt_busy;
    end
  end

  assign bus.holdoff_n = holdoff_n_ff;
endmodule
`default_nettype wire

/* File: smba_procs.sv */
// Processor end: four processors requesting and using the shared memory bus
`timescale 1ns/10ps
`default_nettype none
`include "smba_params.svh"
module smba_procs import smba_pkg::*; #(
  parameter int NUM_PROC = `SMBA_NUM_PROC
) (
  input wire logic mclk, // Board logic clock
  input wire logic rst, // Synchronous reset, active high
  smba_if.procs bus, // Arbiter pins
  input wire logic [NUM_PROC-1:0] need_bus, // User wants external memory
  input wire logic [NUM_PROC-1:0] done, // User finished its transfers
  output logic [NUM_PROC-1:0] owns_ff // Processor may access memory
);
  ////////////////////////////////////////////////////////////////////////
  logic [NUM_PROC-1:0] hold_meta_ff, hold_sync_ff;
  smba_proc_state_e st_ff [NUM_PROC];
  smba_proc_state_e nxt_st [NUM_PROC];
  logic [NUM_PROC-1:0] req_ff, nxt_req, ack_n_ff, nxt_ack_n, nxt_owns;

  always_ff @(posedge mclk) begin
    if (rst) begin
      hold_meta_ff <= '0;
      hold_sync_ff <= '0;
    end else begin
      hold_meta_ff <= bus.holdoff_n;
      hold_sync_ff <= hold_meta_ff;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_PROC; i++) begin
      nxt_st[i] = st_ff[i];
      nxt_req[i] = req_ff[i];
      // Hold acknowledge follows the hold-off input; pins float meanwhile
      nxt_ack_n[i] = hold_sync_ff[i];
      nxt_owns[i] = 1'b0;
      unique case (st_ff[i])
        SMBA_P_IDLE: begin
          if (need_bus[i]) begin
            nxt_req[i] = 1'b1;
            nxt_st[i] = SMBA_P_REQ;
          end
        end
        SMBA_P_REQ: begin
          // Both flags read released: bus is ours; otherwise accesses just stall
          if (hold_sync_ff[i] && ack_n_ff[i]) begin
            nxt_st[i] = SMBA_P_OWN;
            nxt_owns[i] = 1'b1;
          end
        end
        SMBA_P_OWN: begin
          nxt_owns[i] = 1'b1;
          if (done[i]) begin
            nxt_req[i] = 1'b0;
            nxt_owns[i] = 1'b0;
            nxt_st[i] = SMBA_P_DROP;
          end
        end
        SMBA_P_DROP: begin
          if (!hold_sync_ff[i]) begin
            nxt_st[i] = SMBA_P_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < NUM_PROC; i++) begin
      if (rst) begin
        st_ff[i] <= SMBA_P_IDLE;
        req_ff[i] <= 1'b0;
        ack_n_ff[i] <= 1'b0;
        owns_ff[i] <= 1'b0;
      end else begin
        st_ff[i] <= nxt_st[i];
        req_ff[i] <= nxt_req[i];
        ack_n_ff[i] <= nxt_ack_n[i];
        owns_ff[i] <= nxt_owns[i];
      end
    end
  end

  assign bus.bus_request_pin = req_ff;
  assign bus.holdoff_ack_n = ack_n_ff;
endmodule
`default_nettype wire

/* File: smba_asserts.sv */
// Pin-level checks on the arbiter side of the shared bus
`timescale 1ns/10ps
`default_nettype none
module smba_asserts #(parameter int NUM_PROC = 4) (
  input wire logic mclk, // Board clock
  input wire logic rst, // Sync reset
  input wire logic [NUM_PROC-1:0] bus_request_pin, // Requests
  input wire logic [NUM_PROC-1:0] holdoff_n, // Low holds off
  input wire logic [NUM_PROC-1:0] holdoff_ack_n // Low acknowledges hold
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  chk_reset_held: assert property ($past(rst) |-> holdoff_n == '0)
    else $error("hold-off not asserted after reset");
  chk_one_owner: assert property ($onehot0(holdoff_n))
    else $error("two owners");
  chk_idle_held: assert property ((bus_request_pin == '0) [*5] |-> holdoff_n == '0)
    else $error("released while idle");
  for (genvar i = 0; i < NUM_PROC; i++) begin : g_p
    chk_grant_needs_req: assert property ($rose(holdoff_n[i]) |-> $past(bus_request_pin[i], 2))
      else $error("release without request");
    chk_bus_was_free: assert property ($rose(holdoff_n[i]) |-> $past(holdoff_n) == '0)
      else $error("release while bus owned");
    chk_no_preempt: assert property (holdoff_n[i] && bus_request_pin[i] |=> holdoff_n[i])
      else $error("owner pre-empted");
    chk_drop_release: assert property ($fell(bus_request_pin[i]) && holdoff_n[i] |-> ##[1:5] !holdoff_n[i])
      else $error("hold-off not reasserted");
    chk_sync_delay: assert property ($rose(bus_request_pin[i]) |=> !holdoff_n[i] [*2])
      else $error("request used before sync");
    chk_ack_when_held: assert property (!holdoff_n[i] [*4] |-> !holdoff_ack_n[i])
      else $error("held processor not acknowledging");
    chk_ack_when_free: assert property (holdoff_n[i] [*4] |-> holdoff_ack_n[i])
      else $error("released processor still acknowledging");
  end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench joining both ends of the arbiter
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] need_bus = '0;
  logic [3:0] done = '0;
  logic [3:0] owns_ff;
  logic [3:0] grant_ff;
  logic bus_busy_ff;
  logic [31:0] seed = 32'h7a51;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  int last = -1;
  smba_if #(.NUM_PROC(4)) bus_if ();
  smba_arbiter #(.NUM_PROC(4)) i_smba_arbiter (.mclk(mclk), .rst(rst), .bus(bus_if), .grant_ff(grant_ff),
    .bus_busy_ff(bus_busy_ff));
  smba_procs #(.NUM_PROC(4)) i_smba_procs (.mclk(mclk), .rst(rst), .bus(bus_if), .need_bus(need_bus),
    .done(done), .owns_ff(owns_ff));
  smba_asserts #(.NUM_PROC(4)) i_smba_asserts (.mclk(mclk), .rst(rst), .bus_request_pin(bus_if.bus_request_pin),
    .holdoff_n(bus_if.holdoff_n), .holdoff_ack_n(bus_if.holdoff_ack_n));
  ////////////////////////////////////////////////////////////
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Next pending index after the last owner
  function automatic int nxt_rr(input int l, input logic [3:0] p);
    for (int k = 1; k <= 4; k++) begin
      if (p[(l + k) % 4]) return (l + k) % 4;
    end
    return -1;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic serve(input logic [3:0] mask);
    logic [3:0] pend;
    logic [3:0] o;
    int idx;
    int k;
    pend = mask;
    need_bus = need_bus | mask;
    repeat ($countones(mask)) begin
      k = 0;
      while (owns_ff == '0 && k < 40) begin
        @(negedge mclk);
        k++;
      end
      o = owns_ff;
      idx = 0;
      for (int j = 0; j < 4; j++) if (o[j]) idx = j;
      check(o != '0 && pend[idx], 1, "no grant");
      check(bus_if.holdoff_n, o, "holdoff");
      check(grant_ff, o, "grant");
      check(bus_busy_ff, 1, "busy");
      if (last >= 0) check(idx, nxt_rr(last, pend), "order");
      repeat (rnd() % 12 + 1) @(negedge mclk);
      check(owns_ff, o, "tenure");
      done[idx] = 1'b1;
      need_bus[idx] = 1'b0;
      pend[idx] = 1'b0;
      @(negedge mclk);
      done[idx] = 1'b0;
      last = idx;
      repeat (6) @(negedge mclk);
      check(bus_if.holdoff_n[idx], 0, "release");
    end
  endtask
  initial begin
    logic [31:0] r;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    repeat (10) @(negedge mclk);
    check(bus_if.holdoff_n, 0, "idle hold");
    check(bus_busy_ff, 0, "idle busy");
    for (int i = 0; i < 4; i++) serve(4'h1 << i);
    serve(4'hf);
    repeat (20) begin
      r = rnd();
      serve(r[3:0] == 0 ? 4'h5 : r[3:0]);
    end
    need_bus = 4'h1;
    repeat (12) @(negedge mclk);
    need_bus = 4'h5;
    repeat (200) @(negedge mclk);
    check(bus_if.holdoff_n, 4'h1, "lockout");
    rst = 1'b1;
    repeat (3) @(negedge mclk);
    check({bus_if.holdoff_n, grant_ff, bus_busy_ff}, 0, "reset");
    need_bus = '0;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    last = -1;
    serve(4'h6);
    print_verdict();
  end
endmodule
`default_nettype wire
